// ### gmr_top.sv
// general input/output registers and multifunction terminal routing, APB slave
`timescale 1ns/100ps
`include "gmr_params.svh"
module gmr_top
    import gmr_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`GMR_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [6:3]             term_in,
    output logic      [6:3]             term_out,
    output logic      [6:3]             term_oe,
    input  wire logic [2:0]             low_input_level,
    output logic      [4:0]             output_level,
    output logic      [11:0]            low_terminal_select,
    output logic      [3:0]             multi_terminal_6_select,
    input  wire logic                   eeprom_bus_detected,
    input  wire logic                   eeprom_scl_out,
    input  wire logic                   eeprom_scl_oe,
    input  wire logic                   eeprom_load_valid,
    input  wire logic [31:0]            eeprom_load_data,
    input  wire logic                   serialized_interrupt,
    input  wire logic [15:0]            legacy_irq,
    input  wire logic                   bus_grant,
    input  wire logic                   video_port_status,
    input  wire logic                   video_port_select1,
    input  wire logic                   card_audio_pwm,
    input  wire logic                   activity_led1,
    input  wire logic                   socket_led,
    input  wire logic                   event_output,
    output logic      [4:3]             input_event
);
    localparam logic [`GMR_ADDR_W-1:0] ADDR_EVENT   = {`GMR_IDX_EVENT, 2'b00};
    localparam logic [`GMR_ADDR_W-1:0] ADDR_INPUT   = {`GMR_IDX_INPUT, 2'b00};
    localparam logic [`GMR_ADDR_W-1:0] ADDR_OUTPUT  = {`GMR_IDX_OUTPUT, 2'b00};
    localparam logic [`GMR_ADDR_W-1:0] ADDR_ROUTING = {`GMR_IDX_ROUTING, 2'b00};

    gmr_state_type st;
    gmr_state_type next_st;

    logic [4:0]  raw_level;
    logic [4:0]  in_level;
    logic [3:0]  code6;
    logic [3:0]  code5;
    logic [3:0]  code4;
    logic [3:0]  code3;
    logic        setup_phase;
    logic        access_wr;
    logic [31:0] byte_mask;
    logic [31:0] route_wr;
    logic        t5_out;
    logic        t5_oe;
    logic        in4_is_gpi;
    logic        in3_is_gpi;
    logic [1:0]  change;

    // terminals 5 and 4 carry inputs 4 and 3, the rest come from elsewhere
    assign raw_level = {term_in[5], term_in[4], low_input_level};

    gmr_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (raw_level),
        .dout    (in_level)
    );

    // field decode
    assign code6 = st.routing[`GMR_T6_LSB +: 4];
    assign code5 = st.routing[`GMR_T5_LSB +: 4];
    assign code4 = st.routing[`GMR_T4_LSB +: 4];
    assign code3 = st.routing[`GMR_T3_LSB +: 4];

    // bus phases; zero wait states, so the access phase always completes
    assign setup_phase = psel && !penable;
    assign access_wr   = psel && penable && pwrite;
    assign pready      = psel && penable;

    // byte enables widened to a bit mask
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            byte_mask[b*8 +: 8] = {8{pstrb[b]}};
        end
    end

    // merge of a routing write; top nibble never stored
    assign route_wr = (({4'h0, st.routing} & ~byte_mask) | (pwdata & byte_mask))
                      & `GMR_ROUTING_MASK;

    // input event detection only while the terminal acts as an input
    assign in4_is_gpi = (code5 == `GMR_CODE_GPI);
    assign in3_is_gpi = (code4 == `GMR_CODE_GPI) && !eeprom_bus_detected;
    assign change[1]  = st.primed && in4_is_gpi && (in_level[4] != st.prev_in[1]);
    assign change[0]  = st.primed && in3_is_gpi && (in_level[3] != st.prev_in[0]);

    // next state: register writes, eeprom load, event flags, read data
    always_comb begin
        next_st         = st;
        next_st.prev_in = in_level[4:3];
        next_st.primed  = 1'b1;
        // writes take effect at the completing access edge
        if (access_wr) begin
            if (paddr == ADDR_OUTPUT && pstrb[0]) begin
                next_st.out_level = pwdata[4:0];  // bits 7..5 dropped
            end
            if (paddr == ADDR_ROUTING) begin
                next_st.routing = route_wr[27:0];
            end
            if (paddr == ADDR_EVENT && pstrb[0]) begin
                next_st.evt = st.evt & ~pwdata[4:3];
            end
        end
        // an eeprom load overrides a software write in the same cycle
        if (eeprom_load_valid) begin
            next_st.routing = eeprom_load_data[27:0];
        end
        // a change in the clearing cycle still sets the flag
        next_st.evt = next_st.evt | change;
        // read data captured in the setup cycle
        next_st.rdata  = 32'h0000_0000;
        next_st.slverr = 1'b0;
        if (setup_phase) begin
            case (paddr)
                ADDR_INPUT:   next_st.rdata = {27'h000_0000, in_level};
                ADDR_OUTPUT:  next_st.rdata = {27'h000_0000, st.out_level};
                ADDR_ROUTING: next_st.rdata = {4'h0, st.routing};
                ADDR_EVENT:   next_st.rdata = {27'h000_0000, st.evt, 3'h0};
                default:      next_st.slverr = 1'b1;
            endcase
        end
    end

    // registered state; routing starts at its hardware default
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st           <= '0;
            st.out_level <= `GMR_OUTPUT_RESET;
            st.routing   <= 28'(`GMR_ROUTING_RESET);
        end else begin
            st <= next_st;
        end
    end

    assign prdata  = st.rdata;
    assign pslverr = st.slverr && pready;

    // terminal 5 function selector
    gmr_term_mux u_t5_mux (
        .code               (code5),
        .output4_level      (st.out_level[4]),
        .bus_grant          (bus_grant),
        .legacy_irq         (legacy_irq),
        .video_port_status  (video_port_status),
        .video_port_select1 (video_port_select1),
        .card_audio_pwm     (card_audio_pwm),
        .activity_led1      (activity_led1),
        .socket_led         (socket_led),
        .event_output       (event_output),
        .pin_out            (t5_out),
        .pin_oe             (t5_oe)
    );

    // terminal drive; terminal 6 functions live outside, so it stays undriven here
    always_comb begin
        term_out[6] = 1'b0;
        term_oe[6]  = 1'b0;
        term_out[5] = t5_out;
        term_oe[5]  = t5_oe;
        // eeprom mode takes terminal 4 over whatever its field says
        if (eeprom_bus_detected) begin
            term_out[4] = eeprom_scl_out;
            term_oe[4]  = eeprom_scl_oe;
        end else begin
            term_out[4] = 1'b0;
            term_oe[4]  = 1'b0;
        end
        // terminal 3: serial interrupt or one legacy line, code 0 reserved
        term_out[3] = 1'b0;
        term_oe[3]  = 1'b0;
        case (code3)
            4'h0: begin
                term_oe[3] = 1'b0;
            end
            `GMR_CODE_SERIRQ: begin
                term_out[3] = serialized_interrupt;
                term_oe[3]  = 1'b1;
            end
            default: begin
                term_out[3] = legacy_irq[code3];
                term_oe[3]  = 1'b1;
            end
        endcase
    end

    // register images for logic outside this block
    assign output_level            = st.out_level;
    assign low_terminal_select     = st.routing[11:0];
    assign multi_terminal_6_select = code6;
    assign input_event             = st.evt;

    // a setup cycle addressed to one register
    sequence s_setup(logic [`GMR_ADDR_W-1:0] a);
        psel && !penable && paddr == a && !pwrite;
    endsequence

    // a completing write to one register, low byte enabled
    sequence s_write(logic [`GMR_ADDR_W-1:0] a);
        psel && penable && pwrite && paddr == a && pstrb[0];
    endsequence

    a_input_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup(ADDR_INPUT) |=> prdata[4:0] == $past(in_level) && pready)
        else $error("input register read does not show input levels");

    a_reserved_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        (s_setup(ADDR_INPUT) or s_setup(ADDR_OUTPUT)) |=> prdata[31:5] == 27'h000_0000)
        else $error("reserved bits of input or output register not zero");

    a_output_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_write(ADDR_OUTPUT) |=> output_level == $past(pwdata[4:0]))
        else $error("output register write not applied");

    a_output_reset: assert property (
        @(posedge pclk)
        !$past(presetn) |-> output_level == 5'h00)
        else $error("output register not zero after reset");

    a_route_top_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_setup(ADDR_ROUTING) |=> prdata[31:28] == 4'h0 && prdata[27:0] == $past(st.routing))
        else $error("routing register read wrong or top nibble set");

    a_term6_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        term_oe[6] == 1'b0 && multi_terminal_6_select == st.routing[27:24])
        else $error("terminal 6 driven or select mismatched");

    a_term5_table: assert property (
        @(posedge pclk) disable iff (!presetn)
        (code5 == 4'h0 || code5 == 4'hB) |-> !term_oe[5])
        else $error("terminal 5 driven in input or reserved code");

    a_term5_gpo: assert property (
        @(posedge pclk) disable iff (!presetn)
        code5 == 4'h1 |-> term_oe[5] && term_out[5] == output_level[4])
        else $error("terminal 5 does not carry output 4");

    a_eeprom_scl: assert property (
        @(posedge pclk) disable iff (!presetn)
        eeprom_bus_detected |-> term_out[4] == eeprom_scl_out && term_oe[4] == eeprom_scl_oe)
        else $error("terminal 4 not serial clock in eeprom mode");

    a_term3_irq: assert property (
        @(posedge pclk) disable iff (!presetn)
        code3 >= 4'h2 |-> term_oe[3] && term_out[3] == legacy_irq[code3])
        else $error("terminal 3 legacy line mismatched");

    a_term3_reset: assert property (
        @(posedge pclk)
        !$past(presetn) && presetn |-> code3 == 4'h1 && term_out[3] == serialized_interrupt)
        else $error("terminal 3 not serial interrupt after reset");

    a_eeprom_load: assert property (
        @(posedge pclk) disable iff (!presetn)
        eeprom_load_valid |=> st.routing == $past(eeprom_load_data[27:0]))
        else $error("eeprom value not loaded into routing register");

    a_input4_event: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st.primed && code5 == 4'h0 && in_level[4] != st.prev_in[1]) |=> input_event[4])
        else $error("input 4 change did not set its event flag");

    a_event_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        input_event[4] && !(access_wr && paddr == ADDR_EVENT && pstrb[0] && pwdata[4])
        |=> input_event[4])
        else $error("input 4 event flag lost without a clear");

    a_input3_event: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st.primed && code4 == 4'h0 && !eeprom_bus_detected && in_level[3] != st.prev_in[0])
        |=> input_event[3])
        else $error("input 3 change did not set its event flag");

    // terminal 4 is the serial clock then, so it is no input to watch
    a_eeprom_no_event: assert property (
        @(posedge pclk) disable iff (!presetn)
        eeprom_bus_detected && !input_event[3] |=> !input_event[3])
        else $error("input 3 event raised while terminal 4 carries the serial clock");

    a_term4_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        !eeprom_bus_detected |-> !term_oe[4])
        else $error("terminal 4 driven outside eeprom mode");

    a_term3_low_codes: assert property (
        @(posedge pclk) disable iff (!presetn)
        (code3 == 4'h0 |-> !term_oe[3]) and
        (code3 == 4'h1 |-> term_oe[3] && term_out[3] == serialized_interrupt))
        else $error("terminal 3 reserved or serial interrupt code mishandled");

    a_output_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access_wr && paddr == ADDR_OUTPUT && pstrb[0]) |=> $stable(output_level))
        else $error("output register changed without a write");

    a_route_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access_wr && paddr == ADDR_ROUTING) && !eeprom_load_valid |=> $stable(st.routing))
        else $error("routing register changed without a write or load");

    a_route_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        access_wr && paddr == ADDR_ROUTING && pstrb == 4'hF && !eeprom_load_valid
        |=> st.routing == $past(pwdata[27:0]))
        else $error("routing register write not applied");
endmodule : gmr_top

// ### gmr_params.svh
// register offsets, field positions and reset values of the terminal routing block
`ifndef GMR_PARAMS_SVH
`define GMR_PARAMS_SVH
// register indices; the byte address is four times the index
`define GMR_IDX_EVENT       10'h088
`define GMR_IDX_INPUT       10'h08A
`define GMR_IDX_OUTPUT      10'h08B
`define GMR_IDX_ROUTING     10'h08C
`define GMR_ADDR_W          12
// field positions inside the routing register
`define GMR_T6_LSB          24
`define GMR_T5_LSB          20
`define GMR_T4_LSB          16
`define GMR_T3_LSB          12
// reset values and masks
`define GMR_ROUTING_RESET   32'h0000_1000
`define GMR_ROUTING_MASK    32'h0FFF_FFFF
`define GMR_OUTPUT_RESET    5'h00
`define GMR_LEVEL_MASK      32'h0000_001F
`define GMR_EVENT_MASK      32'h0000_0018
// function codes
`define GMR_CODE_GPI        4'h0
`define GMR_CODE_GPO        4'h1
`define GMR_CODE_SERIRQ     4'h1
`define GMR_CODE_T5_RSVD    4'hB
`endif

// ### gmr_pkg.sv
// types shared by the terminal routing block
package gmr_pkg;
    // synchroniser state
    typedef struct packed {
        logic [4:0] meta;
        logic [4:0] stable;
    } gmr_sync_type;

    // state of the register block
    typedef struct packed {
        logic [4:0]  out_level;
        logic [27:0] routing;
        logic [1:0]  evt;
        logic [1:0]  prev_in;
        logic        primed;
        logic [31:0] rdata;
        logic        slverr;
    } gmr_state_type;
endpackage : gmr_pkg

// ### gmr_sync.sv
// two-stage synchroniser for the general input levels
`timescale 1ns/100ps
module gmr_sync
    import gmr_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [4:0] din,
    output logic      [4:0] dout
);
    gmr_sync_type st;
    gmr_sync_type next_st;

    // meta feeds only the stable stage
    always_comb begin
        next_st.meta   = din;
        next_st.stable = st.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.stable;

    // levels arrive exactly two edges late
    a_sync_two_stage: assert property (
        @(posedge pclk) disable iff (!presetn)
        $past(presetn, 2) |-> dout == $past(din, 2))
        else $error("synchroniser depth is not two stages");
endmodule : gmr_sync

// ### gmr_term_mux.sv
// function selector for multifunction terminal 5
`timescale 1ns/100ps
module gmr_term_mux
    import gmr_pkg::*;
(
    input  wire logic [3:0]  code,
    input  wire logic        output4_level,
    input  wire logic        bus_grant,
    input  wire logic [15:0] legacy_irq,
    input  wire logic        video_port_status,
    input  wire logic        video_port_select1,
    input  wire logic        card_audio_pwm,
    input  wire logic        activity_led1,
    input  wire logic        socket_led,
    input  wire logic        event_output,
    output logic             pin_out,
    output logic             pin_oe
);
    // input and reserved codes leave the pin undriven
    always_comb begin
        pin_oe  = 1'b1;
        pin_out = 1'b0;
        case (code)
            4'h0:    pin_oe  = 1'b0;
            4'h1:    pin_out = output4_level;
            4'h2:    pin_out = bus_grant;
            4'h3:    pin_out = legacy_irq[3];
            4'h4:    pin_out = legacy_irq[4];
            4'h5:    pin_out = legacy_irq[5];
            4'h6:    pin_out = video_port_status;
            4'h7:    pin_out = video_port_select1;
            4'h8:    pin_out = card_audio_pwm;
            4'h9:    pin_out = legacy_irq[9];
            4'hA:    pin_out = legacy_irq[10];
            4'hC:    pin_out = activity_led1;
            4'hD:    pin_out = socket_led;
            4'hE:    pin_out = event_output;
            4'hF:    pin_out = legacy_irq[15];
            default: pin_oe  = 1'b0;
        endcase
    end
endmodule : gmr_term_mux

// ### gmr_board_model.sv
// board-level source model: every routed internal signal comes from one bit of a select vector
`timescale 1ns/100ps
module gmr_board_model (
    input  wire logic [15:0] hot,
    output logic             serialized_interrupt,
    output logic      [15:0] legacy_irq,
    output logic             bus_grant,
    output logic             video_port_status,
    output logic             video_port_select1,
    output logic             card_audio_pwm,
    output logic             activity_led1,
    output logic             socket_led,
    output logic             event_output
);
    // bit index equals the function code, so one vector serves terminals 3 and 5 alike;
    // a wrong selection then shows as the opposite level
    assign legacy_irq           = hot;
    assign serialized_interrupt = hot[1];
    assign bus_grant            = hot[2];
    assign video_port_status    = hot[6];
    assign video_port_select1   = hot[7];
    assign card_audio_pwm       = hot[8];
    assign activity_led1        = hot[12];
    assign socket_led           = hot[13];
    assign event_output         = hot[14];
endmodule : gmr_board_model

// ### gpio_and_multifunction_routing_test.sv
// self-checking bench for the general input/output and terminal routing block
`timescale 1ns/100ps
`include "gmr_params.svh"
module gpio_and_multifunction_routing_test;
    localparam logic [11:0] addr_evt = {`GMR_IDX_EVENT, 2'b00};
    localparam logic [11:0] addr_in  = {`GMR_IDX_INPUT, 2'b00};
    localparam logic [11:0] addr_out = {`GMR_IDX_OUTPUT, 2'b00};
    localparam logic [11:0] addr_rte = {`GMR_IDX_ROUTING, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, low_terminal_select;
    logic [31:0] pwdata, prdata, eeprom_load_data;
    logic [3:0]  pstrb, multi_terminal_6_select;
    logic [6:3]  term_in, term_out, term_oe;
    logic [2:0]  low_input_level;
    logic [4:0]  output_level;
    logic [4:3]  input_event;
    logic        eeprom_bus_detected, eeprom_scl_out, eeprom_scl_oe, eeprom_load_valid;
    logic        serialized_interrupt, bus_grant, video_port_status, video_port_select1;
    logic        card_audio_pwm, activity_led1, socket_led, event_output;
    logic [15:0] legacy_irq, hot;
    logic [31:0] v;
    logic        e;
    int          fail_count = 0;
    int          n_checks = 0;
    int          cyc = 0;

    gmr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .term_in(term_in), .term_out(term_out),
        .term_oe(term_oe), .low_input_level(low_input_level), .output_level(output_level),
        .low_terminal_select(low_terminal_select),
        .multi_terminal_6_select(multi_terminal_6_select),
        .eeprom_bus_detected(eeprom_bus_detected), .eeprom_scl_out(eeprom_scl_out),
        .eeprom_scl_oe(eeprom_scl_oe), .eeprom_load_valid(eeprom_load_valid),
        .eeprom_load_data(eeprom_load_data), .serialized_interrupt(serialized_interrupt),
        .legacy_irq(legacy_irq), .bus_grant(bus_grant), .video_port_status(video_port_status),
        .video_port_select1(video_port_select1), .card_audio_pwm(card_audio_pwm),
        .activity_led1(activity_led1), .socket_led(socket_led), .event_output(event_output),
        .input_event(input_event));

    gmr_board_model board (.hot(hot), .serialized_interrupt(serialized_interrupt),
        .legacy_irq(legacy_irq), .bus_grant(bus_grant), .video_port_status(video_port_status),
        .video_port_select1(video_port_select1), .card_audio_pwm(card_audio_pwm),
        .activity_led1(activity_led1), .socket_led(socket_led), .event_output(event_output));

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; the request holds until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        err;
        apb(1'b1, a, d, r, err);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        err;
        apb(1'b0, a, 32'h0000_0000, r, err);
        chk(r, exp);
    endtask : rd

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        logic [15:0] lv;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        term_in = 4'h0;
        low_input_level = 3'h0;
        hot = 16'h0000;
        {eeprom_bus_detected, eeprom_scl_out, eeprom_scl_oe, eeprom_load_valid} = '0;
        eeprom_load_data = 32'h0000_0000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(addr_rte, 32'h0000_1000);
        rd(addr_out, 32'h0000_0000);
        wr(addr_out, 32'hFFFF_FFFF);
        rd(addr_out, 32'h0000_001F);
        chk(output_level, 5'h1F);
        // a write with the low lane off leaves the output register alone
        pstrb <= 4'hE;
        wr(addr_out, 32'h0000_0000);
        pstrb <= 4'hF;
        rd(addr_out, 32'h0000_001F);
        // input 4 rises while terminal 5 is still an input: level and event both show
        term_in <= 4'b0100;
        low_input_level <= 3'b101;
        wr(addr_in, 32'hFFFF_FFFF);
        rd(addr_in, 32'h0000_0015);
        chk(input_event, 2'b10);
        rd(addr_evt, 32'h0000_0010);
        wr(addr_evt, 32'h0000_0010);
        rd(addr_evt, 32'h0000_0000);
        // terminal 5 now an output, terminal 4 still an input: only input 3 raises an event
        // routing is set at the start of this scenario, before its terminals are looked at
        wr(addr_rte, 32'h0010_0000);
        term_in <= 4'b0010;
        repeat (6) @(posedge pclk);
        chk(input_event, 2'b01);
        rd(addr_in, 32'h0000_000D);
        wr(addr_evt, 32'h0000_0008);
        rd(addr_evt, 32'h0000_0000);
        wr(addr_rte, 32'hFFFF_FFFF);
        rd(addr_rte, 32'h0FFF_FFFF);
        chk(low_terminal_select, 12'hFFF);
        // every code on terminals 3 to 6 at once, selected source high then low
        for (int k = 0; k < 16; k++) begin
            for (int p = 0; p < 2; p++) begin
                lv = (p == 0) ? (16'h0001 << k) : ~(16'h0001 << k);
                @(posedge pclk);
                hot <= lv;
                wr(addr_out, {27'h0, lv[1], 4'h0});
                wr(addr_rte, {4'h0, k[3:0], k[3:0], k[3:0], k[3:0], 12'h000});
                @(posedge pclk);
                #1;
                chk(term_oe[5], (k != 0 && k != 11));
                chk(term_oe[3], (k != 0));
                chk(term_oe[6], 1'b0);
                chk(term_oe[4], 1'b0);
                if (k != 0 && k != 11) chk(term_out[5], lv[k]);
                if (k != 0) chk(term_out[3], lv[k]);
            end
        end
        // serial-eeprom mode takes terminal 4 whatever its field holds
        @(posedge pclk);
        eeprom_bus_detected <= 1'b1;
        eeprom_scl_out <= 1'b1;
        eeprom_scl_oe <= 1'b1;
        @(posedge pclk);
        #1;
        chk({term_oe[4], term_out[4]}, 2'b11);
        @(posedge pclk);
        eeprom_scl_out <= 1'b0;
        @(posedge pclk);
        #1;
        chk({term_oe[4], term_out[4]}, 2'b10);
        // routing loaded from the eeprom; the top nibble never lands
        @(posedge pclk);
        eeprom_load_valid <= 1'b1;
        eeprom_load_data <= 32'hF123_4567;
        @(posedge pclk);
        eeprom_load_valid <= 1'b0;
        rd(addr_rte, 32'h0123_4567);
        chk(multi_terminal_6_select, 4'h1);
        // unmapped place: error response and zero data
        apb(1'b0, 12'h3FC, 32'h0000_0000, v, e);
        chk(e, 1'b1);
        chk(v, 32'h0000_0000);
        print_verdict();
    end
endmodule : gpio_and_multifunction_routing_test
